// ==== src/ccsc_defs.vh ====
// Register map, field positions, reset values and timing counts of the clamp and coast control.
`ifndef CCSC_DEFS_VH
`define CCSC_DEFS_VH

`define CCSC_OFF_COAST_CLAMP    8'h18
`define CCSC_OFF_START_DELAY    8'h19
`define CCSC_OFF_CLAMP_LENGTH   8'h1A
`define CCSC_OFF_POL_AUTOOFF    8'h1B
`define CCSC_OFF_TEST_VALUE     8'h1C
`define CCSC_OFF_SLICER         8'h1D
`define CCSC_OFF_POWER_CHANNEL  8'h1E

`define CCSC_RST_COAST_CLAMP    8'h20
`define CCSC_RST_START_DELAY    8'h08
`define CCSC_RST_CLAMP_LENGTH   8'h20
`define CCSC_RST_POL_AUTOOFF    8'h5B
`define CCSC_RST_TEST_VALUE     8'hFF
`define CCSC_RST_SLICER         8'h78
`define CCSC_RST_POWER_CHANNEL  8'h30

`define CCSC_B_HOLD_SRC         7
`define CCSC_B_HOLD_POL_OVR     6
`define CCSC_B_HOLD_POL         5
`define CCSC_B_CLAMP_SRC        4
`define CCSC_B_RED_MID          3
`define CCSC_B_GREEN_MID        2
`define CCSC_B_BLUE_MID         1
`define CCSC_B_CLAMP_POL_OVR    7
`define CCSC_B_CLAMP_POL        6
`define CCSC_B_AUTO_OFF_EN      5
`define CCSC_B_UPD_HI           4
`define CCSC_B_UPD_LO           3
`define CCSC_B_THR_HI           7
`define CCSC_B_THR_LO           3
`define CCSC_B_SYNC_OUT_POL     2
`define CCSC_B_CHAN_OVR         7
`define CCSC_B_CHAN_SEL         6

`define CCSC_UPD_CLAMPS_0       8'd3
`define CCSC_UPD_CLAMPS_1       8'd48
`define CCSC_UPD_CLAMPS_2       8'd192
`define CCSC_UPD_FRAMES_3       8'd3

`endif

// ==== src/ccsc_clamp_coast_sync_control.v ====
// Clamp, hold and embedded-sync control registers with their pulse and select logic.
//
// The APB slave port was decided locally.
`include "ccsc_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module ccsc_clamp_coast_sync_control (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        line_sync_input_0,
  input  wire        line_sync_input_1,
  input  wire        green_embedded_sync_0,
  input  wire        green_embedded_sync_1,
  input  wire        frame_sync,
  input  wire        regen_sync,
  input  wire        filtered_sync,
  input  wire        ext_hold,
  input  wire        ext_hold_auto_high,
  input  wire        ext_clamp,
  input  wire        ext_clamp_auto_high,
  input  wire        sync_on_1_detected,
  input  wire        sync_on_0_detected,
  output reg         pll_hold,
  output reg         clamp_pulse,
  output reg  [2:0]  clamp_midscale,
  output reg         auto_offset_en,
  output reg         offset_update,
  output reg  [4:0]  slicer_threshold,
  output reg         embedded_sync_output,
  output reg         channel_pair,
  output reg  [7:0]  test_value
);

  // ==========================================================================
  // Register file
  // ==========================================================================
  localparam NREG = 7;

  wire [7:0] wordAddr = paddr[9:2];
  wire       aligned  = (paddr[1:0] == 2'b00) && (paddr[31:10] == 22'h00_0000);
  wire       hit      = aligned && (wordAddr >= `CCSC_OFF_COAST_CLAMP) &&
                        (wordAddr <= `CCSC_OFF_POWER_CHANNEL);
  wire [7:0] idxWide  = wordAddr - `CCSC_OFF_COAST_CLAMP;
  wire [2:0] idx      = idxWide[2:0];
  wire       access   = psel && penable && !pready;

  genvar g;
  generate
    for (g = 0; g < NREG; g = g + 1) begin : gReg
      // Each register resets straight to its default, a constant per entry.
      localparam [7:0] RST_VAL = (g == 0) ? `CCSC_RST_COAST_CLAMP :
                                 (g == 1) ? `CCSC_RST_START_DELAY :
                                 (g == 2) ? `CCSC_RST_CLAMP_LENGTH :
                                 (g == 3) ? `CCSC_RST_POL_AUTOOFF :
                                 (g == 4) ? `CCSC_RST_TEST_VALUE :
                                 (g == 5) ? `CCSC_RST_SLICER :
                                 `CCSC_RST_POWER_CHANNEL;
      reg [7:0] value;
      always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          value <= RST_VAL;
        end else if (access && pwrite && hit && idx == g) begin
          value <= pwdata[7:0];
        end
      end
    end
  endgenerate

  wire [7:0] rCtl   = gReg[0].value;
  wire [7:0] rDelay = gReg[1].value;
  wire [7:0] rLen   = gReg[2].value;
  wire [7:0] rPol   = gReg[3].value;
  wire [7:0] rTest  = gReg[4].value;
  wire [7:0] rSlc   = gReg[5].value;
  wire [7:0] rPwr   = gReg[6].value;

  // ==========================================================================
  // APB slave: one wait state, unmapped addresses answer with pslverr
  // ==========================================================================
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= access;
      pslverr <= access && !hit;
      if (access && !pwrite && hit) begin
        case (idx)
          3'd0:    prdata <= {24'h00_0000, rCtl};
          3'd1:    prdata <= {24'h00_0000, rDelay};
          3'd2:    prdata <= {24'h00_0000, rLen};
          3'd3:    prdata <= {24'h00_0000, rPol};
          3'd4:    prdata <= {24'h00_0000, rTest};
          3'd5:    prdata <= {24'h00_0000, rSlc};
          3'd6:    prdata <= {24'h00_0000, rPwr};
          default: prdata <= 32'h0000_0000;
        endcase
      end else if (access) begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ==========================================================================
  // Channel pair and sync selection
  // ==========================================================================
  reg  autoPair;
  wire manualPair = rPwr[`CCSC_B_CHAN_OVR] ||
                    (sync_on_0_detected && sync_on_1_detected);
  wire next_pair  = manualPair ? rPwr[`CCSC_B_CHAN_SEL] : autoPair;
  always @* begin
    autoPair = sync_on_1_detected && !sync_on_0_detected;
  end

  wire lineSync = channel_pair ? line_sync_input_1 : line_sync_input_0;
  wire rawSlice = channel_pair ? green_embedded_sync_1 : green_embedded_sync_0;

  // ==========================================================================
  // Internal clamp pulse timed from the trailing edge of line sync
  // ==========================================================================
  localparam ST_IDLE  = 3'b001;
  localparam ST_DELAY = 3'b010;
  localparam ST_CLAMP = 3'b100;
  reg [2:0] state;
  reg [7:0] count;
  reg       lineSyncQ;
  wire      syncEnd = lineSyncQ && !lineSync;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= ST_IDLE;
      count     <= 8'h00;
      lineSyncQ <= 1'b0;
    end else begin
      lineSyncQ <= lineSync;
      if (rCtl[`CCSC_B_CLAMP_SRC]) begin
        state <= ST_IDLE;
        count <= 8'h00;
      end else begin
        case (state)
          ST_IDLE: begin
            if (syncEnd) begin
              state <= ST_DELAY;
              count <= 8'h01;
            end
          end
          ST_DELAY: begin
            if (count >= rDelay) begin
              state <= (rLen == 8'h00) ? ST_IDLE : ST_CLAMP;
              count <= 8'h01;
            end else begin
              count <= count + 8'h01;
            end
          end
          ST_CLAMP: begin
            if (count >= rLen) begin
              state <= ST_IDLE;
            end else begin
              count <= count + 8'h01;
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // ==========================================================================
  // Output stage
  // ==========================================================================
  wire holdHigh  = rCtl[`CCSC_B_HOLD_POL_OVR] ? rCtl[`CCSC_B_HOLD_POL] :
                   ext_hold_auto_high;
  wire clampHigh = rPol[`CCSC_B_CLAMP_POL_OVR] ? rPol[`CCSC_B_CLAMP_POL] :
                   ext_clamp_auto_high;
  wire intClamp  = (state == ST_CLAMP);
  wire extActive = ext_clamp == clampHigh;
  reg  sliceSrc;
  always @* begin
    case (rSlc[1:0])
      2'b00:   sliceSrc = rawSlice;
      2'b01:   sliceSrc = lineSync;
      2'b10:   sliceSrc = regen_sync;
      default: sliceSrc = filtered_sync;
    endcase
  end

  // Offset loop pacing counts clamps or frame syncs.
  reg [7:0] updCount;
  reg       frameQ;
  reg       clampQ;
  wire      frameEdge = frame_sync && !frameQ;
  wire      clampEnd  = clampQ && !clamp_pulse;
  wire      useFrames = (rPol[`CCSC_B_UPD_HI:`CCSC_B_UPD_LO] == 2'b11);
  wire      tick      = useFrames ? frameEdge : clampEnd;
  reg [7:0] updLimit;
  always @* begin
    case (rPol[`CCSC_B_UPD_HI:`CCSC_B_UPD_LO])
      2'b00:   updLimit = `CCSC_UPD_CLAMPS_0;
      2'b01:   updLimit = `CCSC_UPD_CLAMPS_1;
      2'b10:   updLimit = `CCSC_UPD_CLAMPS_2;
      default: updLimit = `CCSC_UPD_FRAMES_3;
    endcase
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pll_hold             <= 1'b0;
      clamp_pulse          <= 1'b0;
      clamp_midscale       <= 3'h0;
      auto_offset_en       <= 1'b0;
      offset_update        <= 1'b0;
      slicer_threshold     <= 5'h0F;
      embedded_sync_output <= 1'b1;
      channel_pair         <= 1'b0;
      test_value           <= 8'hFF;
      updCount             <= 8'h00;
      frameQ               <= 1'b0;
      clampQ               <= 1'b0;
    end else begin
      frameQ   <= frame_sync;
      clampQ   <= clamp_pulse;
      pll_hold <= rCtl[`CCSC_B_HOLD_SRC] ? (ext_hold == holdHigh) : frame_sync;
      clamp_pulse <= rCtl[`CCSC_B_CLAMP_SRC] ? extActive : intClamp;
      clamp_midscale <= rCtl[`CCSC_B_RED_MID:`CCSC_B_BLUE_MID];
      auto_offset_en <= rPol[`CCSC_B_AUTO_OFF_EN];
      slicer_threshold <= rSlc[`CCSC_B_THR_HI:`CCSC_B_THR_LO];
      embedded_sync_output <= rSlc[`CCSC_B_SYNC_OUT_POL] ? sliceSrc : !sliceSrc;
      channel_pair <= next_pair;
      test_value   <= rTest;
      offset_update <= 1'b0;
      if (!rPol[`CCSC_B_AUTO_OFF_EN]) begin
        updCount <= 8'h00;
      end else if (tick) begin
        if (updCount + 8'h01 >= updLimit) begin
          updCount      <= 8'h00;
          offset_update <= 1'b1;
        end else begin
          updCount <= updCount + 8'h01;
        end
      end
    end
  end

endmodule

`default_nettype wire

// ==== testbench/ccsc_checker_sva.sv ====
// Checker of bus timing and register effects at the ports of the clamp and coast control.
`include "ccsc_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module ccsc_checker (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        line_sync_input_0,
  input wire logic        line_sync_input_1,
  input wire logic        green_embedded_sync_0,
  input wire logic        green_embedded_sync_1,
  input wire logic        frame_sync,
  input wire logic        regen_sync,
  input wire logic        filtered_sync,
  input wire logic        ext_hold,
  input wire logic        ext_hold_auto_high,
  input wire logic        ext_clamp,
  input wire logic        ext_clamp_auto_high,
  input wire logic        pll_hold,
  input wire logic        clamp_pulse,
  input wire logic [2:0]  clamp_midscale,
  input wire logic [4:0]  slicer_threshold,
  input wire logic        embedded_sync_output,
  input wire logic        channel_pair
);
  logic [7:0]  ctl, pol, slc, pwr, len, hiCnt;
  logic [51:0] v1, v2, v3;
  wire         w = psel && penable && pready && pwrite;
  wire [51:0]  v = {ctl, pol, slc, pwr, len, frame_sync, ext_hold, ext_clamp, ext_hold_auto_high,
    ext_clamp_auto_high, line_sync_input_0, line_sync_input_1, green_embedded_sync_0,
    green_embedded_sync_1, regen_sync, filtered_sync, channel_pair};
  // Hold, clamp source, midscale, slicer and channel pair outputs are judged only once inputs and settings have been still for three cycles.
  wire         quiet = v == v1 && v1 == v2 && v2 == v3;
  wire         eh = !ctl[7] ? frame_sync : ext_hold == (ctl[6] ? ctl[5] : ext_hold_auto_high);
  wire         ec = ext_clamp == (pol[7] ? pol[6] : ext_clamp_auto_high);
  wire [3:0]   srcs = channel_pair ?
    {filtered_sync, regen_sync, line_sync_input_1, green_embedded_sync_1} :
    {filtered_sync, regen_sync, line_sync_input_0, green_embedded_sync_0};
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl <= `CCSC_RST_COAST_CLAMP;
      pol <= `CCSC_RST_POL_AUTOOFF;
      slc <= `CCSC_RST_SLICER;
      pwr <= `CCSC_RST_POWER_CHANNEL;
      len <= `CCSC_RST_CLAMP_LENGTH;
      {v1, v2, v3, hiCnt} <= '0;
    end else begin
      {v1, v2, v3} <= {v, v1, v2};
      hiCnt <= clamp_pulse ? hiCnt + 8'h01 : 8'h00;
      if (w && paddr[7:0] == 8'h60) ctl <= pwdata[7:0];
      if (w && paddr[7:0] == 8'h68) len <= pwdata[7:0];
      if (w && paddr[7:0] == 8'h6C) pol <= pwdata[7:0];
      if (w && paddr[7:0] == 8'h74) slc <= pwdata[7:0];
      if (w && paddr[7:0] == 8'h78) pwr <= pwdata[7:0];
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready high for more than one cycle");
  pready_answer_a: assert property (psel && penable && !pready |=> pready)
    else $error("no answer one cycle after the access edge");
  hold_select_a: assert property (quiet |-> pll_hold == eh)
    else $error("pll hold does not follow its selected source");
  clamp_ext_a: assert property (quiet && ctl[4] |-> clamp_pulse == ec)
    else $error("external clamp not passed with its polarity");
  clamp_midscale_a: assert property (quiet |-> clamp_midscale == ctl[3:1])
    else $error("clamp targets differ from control bits");
  slicer_out_a: assert property (quiet |-> slicer_threshold == slc[7:3]
    && embedded_sync_output == (srcs[slc[1:0]] == slc[2])) else $error("sync output wrong");
  channel_pair_a: assert property (quiet && pwr[7] |-> channel_pair == pwr[6])
    else $error("manual channel pair not applied");
  clamp_len_a: assert property ($fell(clamp_pulse) && !ctl[4] && !$past(ctl[4]) |-> hiCnt == len)
    else $error("internal clamp length differs from setting");
endmodule
bind ccsc_clamp_coast_sync_control ccsc_checker ccsc_checker_i (.*);
`default_nettype wire

// ==== testbench/ccsc_video_source.sv ====
// Video source model that sends one line sync pulse per request.
`timescale 1ns/1ps
`default_nettype none
module ccsc_video_source #(parameter int W = 6) (
  input  wire logic ref_clk,
  input  wire logic lineGo,
  output wire logic lineSync
);
  int n = 0;
  always @(posedge ref_clk) begin
    if (lineGo) n <= W;
    else if (n > 0) n <= n - 1;
  end
  assign lineSync = n != 0;
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// Self-checking bench of the clamp and coast control registers.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin failures++; $display("wrong value %s exp %h got %h", n, e, s); end end
module tb;
  logic        ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, lineGo = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata;
  logic        pready, pslverr, pll_hold, clamp_pulse, auto_offset_en, offset_update;
  logic        embedded_sync_output, channel_pair, rerr, frame_sync, regen_sync, filtered_sync;
  logic        line_sync_input_0, line_sync_input_1, green_embedded_sync_0, ext_hold;
  logic        green_embedded_sync_1, ext_hold_auto_high, ext_clamp, ext_clamp_auto_high;
  logic        sync_on_0_detected, sync_on_1_detected;
  logic [2:0]  clamp_midscale;
  logic [4:0]  slicer_threshold;
  logic [7:0]  test_value, rdat;
  logic [11:0] pins = 0;
  int          failures = 0, check_count = 0, upd = 0, c, h;
  logic [7:0]  rv [7] = '{8'h20, 8'h08, 8'h20, 8'h5B, 8'hFF, 8'h78, 8'h30};
  logic [7:0]  ra [9] = '{8'h60, 8'h64, 8'h68, 8'h6C, 8'h70, 8'h74, 8'h78, 8'h7C, 8'h62};
  logic [7:0]  rd [9] = '{8'hEE, 8'h03, 8'h05, 8'hDB, 8'hFF, 8'h47, 8'hC0, 8'h55, 8'h11};
  // Control bit 0 stays 0, offset low bits stay 011, test value stays all ones.
  logic [31:0] cfg [4] = '{32'hEEDB_47C0, 32'h901B_0400, 32'hD09B_8180, 32'h105B_7A00};
  assign {sync_on_0_detected, sync_on_1_detected, ext_clamp_auto_high, ext_clamp,
    ext_hold_auto_high, ext_hold, filtered_sync, regen_sync, green_embedded_sync_1,
    green_embedded_sync_0, line_sync_input_1, frame_sync} = pins;
  ccsc_clamp_coast_sync_control ccsc_clamp_coast_sync_control_i (.*);
  ccsc_video_source ccsc_video_source_i (.ref_clk(ref_clk), .lineGo(lineGo),
    .lineSync(line_sync_input_0));
  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (offset_update === 1'b1) upd++;
  task print_verdict;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic apb(input logic [7:0] a, input logic wr, input logic [7:0] d);
    int k = 0;
    psel <= 1;
    pwrite <= wr;
    paddr <= {24'h00_0000, a};
    pwdata <= {24'h00_0000, d};
    @(posedge ref_clk);
    penable <= 1;
    do begin @(posedge ref_clk); k++; end while (pready !== 1'b1 && k < 20);
    rdat = prdata[7:0];
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
    if (pready !== 1'b1) begin failures++; print_verdict(); end
    @(posedge ref_clk);
  endtask
  task automatic rst;
    rst_n <= 0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1;
    @(posedge ref_clk);
  endtask
  task automatic line;
    lineGo <= 1;
    @(posedge ref_clk);
    lineGo <= 0;
    repeat (2) @(posedge ref_clk);
    c = 0;
    h = 0;
    while (line_sync_input_0 === 1'b1 && c < 300) begin @(posedge ref_clk); c++; end
    c = 0;
    while (clamp_pulse !== 1'b1 && c < 300) begin @(posedge ref_clk); c++; end
    while (clamp_pulse === 1'b1 && h < 300) begin @(posedge ref_clk); h++; end
    if (c == 300 || h == 300) begin failures++; print_verdict(); end
  endtask
  initial begin
    rst();
    `CHK("threshold", 5'h0F, slicer_threshold)
    `CHK("test value", 8'hFF, test_value)
    for (int i = 0; i < 7; i++) begin
      apb(8'h60 + 8'(4 * i), 0, 0);
      `CHK("reset value", rv[i], rdat)
    end
    $display("reset test done");
    for (int i = 0; i < 9; i++) begin
      apb(ra[i], 1, rd[i]);
      apb(ra[i], 0, 0);
      `CHK("read back", (i < 7 ? rd[i] : 8'h00), rdat)
      `CHK("error", (i >= 7), rerr)
    end
    $display("register test done");
    for (int i = 0; i < 4; i++) begin
      apb(8'h60, 1, cfg[i][31:24]);
      apb(8'h6C, 1, cfg[i][23:16]);
      apb(8'h74, 1, cfg[i][15:8]);
      apb(8'h78, 1, cfg[i][7:0]);
      for (int p = 0; p < 4096; p++) begin pins <= 12'(p); repeat (4) @(posedge ref_clk); end
    end
    pins <= 0;
    $display("select test done");
    apb(8'h60, 1, 8'h00);
    for (int i = 0; i < 2; i++) begin
      apb(8'h64, 1, 8'(3 * i));
      apb(8'h68, 1, 8'(1 + 4 * i));
      line();
      `CHK("clamp delay", 1'b1, (c >= 3 * i && c <= 3 * i + 3))
      `CHK("clamp length", 1 + 4 * i, h)
    end
    $display("clamp test done");
    rst();
    apb(8'h6C, 1, 8'h63);
    upd = 0;
    repeat (6) line();
    repeat (5) @(posedge ref_clk);
    `CHK("updates per clamps", 2, upd)
    `CHK("auto offset", 1'b1, auto_offset_en)
    apb(8'h6C, 1, 8'h7B);
    upd = 0;
    repeat (9) begin
      pins <= 1;
      repeat (3) @(posedge ref_clk);
      pins <= 0;
      repeat (3) @(posedge ref_clk);
    end
    repeat (5) @(posedge ref_clk);
    `CHK("updates per frames", 3, upd)
    $display("offset test done");
    print_verdict();
  end
endmodule
`default_nettype wire
